// ===== pimg_consts.svh
// constants shared by both ends of the process-image register channel
`ifndef PIMG_CONSTS_SVH
`define PIMG_CONSTS_SVH

// ----------------------------------------------------------------------
// control and status byte layout
// ----------------------------------------------------------------------
`define CB_REG_MODE_BIT 7
`define CB_WRITE_BIT 6
`define CB_REGNUM_MSB 5
`define CB_REGNUM_LSB 0

// ----------------------------------------------------------------------
// terminal register numbers
// ----------------------------------------------------------------------
`define REG_FW_REVISION 6'h09
`define REG_UNLOCK_CODE 6'h1F
`define REG_OP_FEATURES 6'h20

// ----------------------------------------------------------------------
// values and reset values
// ----------------------------------------------------------------------
`define UNLOCK_VALUE 16'h1235
`define UNLOCK_CODE_RST 16'h0000
`define OP_FEATURES_RST 16'h0000
// arbitrary neutral revision text "0X"
`define FW_REVISION_DEFAULT 16'h3058
`define BYTE_ZERO 8'h00
`define WORD_ZERO 16'h0000

// ----------------------------------------------------------------------
// controller APB register map
// ----------------------------------------------------------------------
`define HOST_OFS_CMD 8'h00
`define HOST_OFS_STATUS 8'h04
`define HOST_OFS_RDATA 8'h08
`define HOST_OFS_PDOUT 8'h0C
`define HOST_OFS_PDIN 8'h10
`define CMD_DATA_LSB 16
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_DIR_BIT 2
`define PDIN_STAT_LSB 16

`endif

// ===== pimg_pkg.sv
// types shared by both ends of the process-image register channel
package pimg_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
  typedef logic [5:0] regnum_t;
  typedef logic [31:0] apb_data_t;
  typedef enum logic [2:0] {
    HOST_IDLE = 3'b001,
    HOST_WAIT = 3'b010,
    HOST_RELEASE = 3'b100
  } host_state_e;
endpackage : pimg_pkg

// ===== pimg_if.sv
// process-image exchange between controller and terminal
`timescale 1ns/1ps
interface pimg_if;
  import pimg_pkg::*;
  byte_t ctrlByte;
  word_t outputDataWord;
  byte_t statusByte;
  word_t inputDataWord;

  modport terminal (
    input ctrlByte,
    input outputDataWord,
    output statusByte,
    output inputDataWord
  );

  modport controller (
    output ctrlByte,
    output outputDataWord,
    input statusByte,
    input inputDataWord
  );
endinterface : pimg_if

// ===== process_image_terminal.sv
// terminal end of the process-image register channel
//
// Functional notes
// [R01] control bit 7 selects register communication
// [R02] control bit 6: clear reads, set writes
// [R03] control bits 5..0 give register number
// [R04] read acknowledged with exact control byte copy
// [R05] write acknowledged with bit 6 cleared
// [R06] read returns register, high byte first
// [R07] output word ignored during reads
// [R08] controller places new value with write byte
// [R09] controller discards input word after writes
// [R10] locked: only code word register writable
// [R11] writing unlock value lifts write protection
// [R12] any other code value relocks
// [R13] new features act only after restart
// [R14] revision register returns two ASCII characters
// [R15] feature register is number 32
// [R16] restart clears the unlock code
// [R17] controller holds request until acknowledged
`timescale 1ns/1ps
`include "pimg_consts.svh"

module process_image_terminal #(
  parameter logic [15:0] FW_REVISION = `FW_REVISION_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  pimg_if.terminal pi,
  input wire logic restartReq,
  input wire pimg_pkg::byte_t procStatus,
  input wire pimg_pkg::word_t procInWord,
  output pimg_pkg::word_t procOutWord,
  output pimg_pkg::word_t activeFeatures,
  output logic writeUnlocked,
  output logic regModeActive
);
  import pimg_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  generate
    if (FW_REVISION[15:8] == `BYTE_ZERO) begin : g_bad_rev
      $error("firmware revision needs a printable first character");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  word_t unlockCode_q;
  word_t featRam_q;
  word_t featStore_q;
  word_t activeFeat_q;
  byte_t status_q;
  byte_t status_d;
  word_t inWord_q;
  word_t inWord_d;
  word_t procOut_q;
  word_t procOut_d;
  logic unlocked_q;
  logic regMode_q;

  // ----------------------------------------------------------------------
  // control byte decode
  // ----------------------------------------------------------------------
  wire regMode = pi.ctrlByte[`CB_REG_MODE_BIT]; // [R01]
  wire isWrite = pi.ctrlByte[`CB_WRITE_BIT]; // [R02]
  wire regnum_t regNum = pi.ctrlByte[`CB_REGNUM_MSB:`CB_REGNUM_LSB]; // [R03]

  wire hitRevision = (regNum == `REG_FW_REVISION);
  wire hitUnlock = (regNum == `REG_UNLOCK_CODE);
  wire hitFeatures = (regNum == `REG_OP_FEATURES); // [R15]

  wire readReq = regMode & ~isWrite;
  wire writeReq = regMode & isWrite;

  // ----------------------------------------------------------------------
  // write protection
  // ----------------------------------------------------------------------
  // the unlock register is always writable; every other one needs the code
  wire codeMatches = (unlockCode_q == `UNLOCK_VALUE); // [R11] [R12]
  wire writeUnlock = writeReq & hitUnlock; // [R10]
  wire writeFeatures = writeReq & hitFeatures & codeMatches; // [R10] [R11]

  // ----------------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------------
  // revision bytes are ASCII, first character in the high byte
  wire word_t revisionWord = FW_REVISION; // [R14]
  wire word_t unlockWord = unlockCode_q;
  wire word_t featureWord = featRam_q;
  wire word_t readData =
    hitRevision ? revisionWord :
    hitUnlock ? unlockWord :
    hitFeatures ? featureWord :
    `WORD_ZERO; // [R06]

  // ----------------------------------------------------------------------
  // acknowledge byte
  // ----------------------------------------------------------------------
  wire byte_t readAck = pi.ctrlByte; // [R04]
  wire byte_t writeAck = {pi.ctrlByte[`CB_REG_MODE_BIT], 1'b0,
    pi.ctrlByte[`CB_REGNUM_MSB:`CB_REGNUM_LSB]}; // [R05]

  // ----------------------------------------------------------------------
  // process image answer
  // ----------------------------------------------------------------------
  // bit 7 of the status is kept low in process mode so the controller can
  // tell a finished register exchange from plain process data
  always_comb begin
    status_d = {1'b0, procStatus[6:0]};
    inWord_d = procInWord;
    procOut_d = pi.outputDataWord;
    if (regMode) begin
      procOut_d = procOut_q; // [R07]
      if (isWrite) begin
        status_d = writeAck; // [R05]
        // input word is meaningless after a write; keep the last value
        inWord_d = inWord_q;
      end else begin
        status_d = readAck; // [R04]
        inWord_d = readData; // [R06]
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= `BYTE_ZERO;
      inWord_q <= `WORD_ZERO;
      procOut_q <= `WORD_ZERO;
      regMode_q <= 1'b0;
    end else begin
      status_q <= status_d;
      inWord_q <= inWord_d;
      procOut_q <= procOut_d;
      regMode_q <= regMode;
    end
  end

  // ----------------------------------------------------------------------
  // unlock code register
  // ----------------------------------------------------------------------
  // a held write request rewrites the same value every cycle, which is
  // harmless because the store is idempotent
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unlockCode_q <= `UNLOCK_CODE_RST;
    end else if (restartReq) begin
      unlockCode_q <= `UNLOCK_CODE_RST; // [R16]
    end else if (writeUnlock) begin
      unlockCode_q <= pi.outputDataWord; // [R11] [R12]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unlocked_q <= 1'b0;
    end else begin
      unlocked_q <= codeMatches;
    end
  end

  // ----------------------------------------------------------------------
  // feature register
  // ----------------------------------------------------------------------
  // featStore_q models the nonvolatile copy: it survives restartReq and is
  // only lost by reset_n, which stands for the very first power-up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      featStore_q <= `OP_FEATURES_RST;
    end else if (writeFeatures && !restartReq) begin
      featStore_q <= pi.outputDataWord; // [R15]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      featRam_q <= `OP_FEATURES_RST;
    end else if (restartReq) begin
      featRam_q <= featStore_q;
    end else if (writeFeatures) begin
      featRam_q <= pi.outputDataWord; // [R10]
    end
  end

  // behaviour follows only the value taken at restart
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      activeFeat_q <= `OP_FEATURES_RST;
    end else if (restartReq) begin
      activeFeat_q <= featStore_q; // [R13]
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign pi.statusByte = status_q;
  assign pi.inputDataWord = inWord_q;
  assign procOutWord = procOut_q;
  assign activeFeatures = activeFeat_q;
  assign writeUnlocked = unlocked_q;
  assign regModeActive = regMode_q;

endmodule : process_image_terminal

// ===== process_image_controller.sv
// controller end of the process-image register channel, APB slave
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "pimg_consts.svh"

module process_image_controller #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire pimg_pkg::apb_data_t pwdata,
  output pimg_pkg::apb_data_t prdata,
  output logic pready,
  output logic pslverr,
  pimg_if.controller pi
);
  import pimg_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  generate
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
      $error("ADDR_W must be 5 to 8");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  host_state_e state_q;
  byte_t ctrl_q;
  word_t outWord_q;
  word_t rdData_q;
  word_t pdOut_q;
  byte_t pdStat_q;
  word_t pdIn_q;
  logic done_q;
  apb_data_t prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire [7:0] addr = 8'(paddr);
  wire access = psel & penable;
  wire answer = access & ~pready_q;
  wire commit = access & pready_q;
  wire selCmd = (addr == `HOST_OFS_CMD);
  wire selStat = (addr == `HOST_OFS_STATUS);
  wire selRd = (addr == `HOST_OFS_RDATA);
  wire selPdOut = (addr == `HOST_OFS_PDOUT);
  wire selPdIn = (addr == `HOST_OFS_PDIN);
  wire mapped = selCmd | selStat | selRd | selPdOut | selPdIn;
  wire idle = (state_q == HOST_IDLE);
  // a new command while one is open is refused with an error
  wire busyErr = pwrite & selCmd & ~idle;
  // a command refused at the answer edge stays refused even if the channel
  // has gone idle by the commit edge
  wire start = commit & pwrite & selCmd & idle & ~pslverr_q;
  wire clrDone = commit & pwrite & selStat & pwdata[`ST_DONE_BIT];

  wire apb_data_t statWord = {29'h0, ctrl_q[`CB_WRITE_BIT], done_q, ~idle};
  wire apb_data_t rdSel =
    selCmd ? {outWord_q, 8'h00, ctrl_q} :
    selStat ? statWord :
    selRd ? {16'h0000, rdData_q} :
    selPdOut ? {16'h0000, pdOut_q} :
    selPdIn ? {8'h00, pdStat_q, pdIn_q} :
    32'h0000_0000;

  // ----------------------------------------------------------------------
  // request and acknowledge
  // ----------------------------------------------------------------------
  wire byte_t expectAck = ctrl_q[`CB_WRITE_BIT] ?
    {ctrl_q[`CB_REG_MODE_BIT], 1'b0, ctrl_q[`CB_REGNUM_MSB:0]} : ctrl_q;
  wire acked = (state_q == HOST_WAIT) && (pi.statusByte == expectAck);
  wire byte_t startCtrl = {1'b1, pwdata[`CB_WRITE_BIT],
    pwdata[`CB_REGNUM_MSB:0]}; // [R01] [R02] [R03]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= HOST_IDLE;
      ctrl_q <= `BYTE_ZERO;
      outWord_q <= `WORD_ZERO;
    end else begin
      case (state_q)
        HOST_IDLE: begin
          outWord_q <= pdOut_q;
          if (start) begin
            ctrl_q <= startCtrl; // [R01]
            // [R08] [R11] [R15]
            outWord_q <= pwdata[`CMD_DATA_LSB +: 16];
            state_q <= HOST_WAIT;
          end
        end
        HOST_WAIT: begin
          // request held unchanged until its acknowledge
          if (acked) begin // [R17]
            ctrl_q <= {1'b0, ctrl_q[6:0]};
            state_q <= HOST_RELEASE;
          end
        end
        HOST_RELEASE: begin
          outWord_q <= pdOut_q;
          if (!pi.statusByte[`CB_REG_MODE_BIT]) begin
            state_q <= HOST_IDLE;
          end
        end
        default: begin
          state_q <= HOST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // captured data
  // ----------------------------------------------------------------------
  // read data only after a read; write answers are never captured
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= `WORD_ZERO;
    end else if (acked && !ctrl_q[`CB_WRITE_BIT]) begin
      rdData_q <= pi.inputDataWord; // [R09]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pdStat_q <= `BYTE_ZERO;
      pdIn_q <= `WORD_ZERO;
    end else if (idle && !pi.statusByte[`CB_REG_MODE_BIT]) begin
      pdStat_q <= pi.statusByte;
      pdIn_q <= pi.inputDataWord;
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pdOut_q <= `WORD_ZERO;
      done_q <= 1'b0;
    end else begin
      if (commit && pwrite && selPdOut) begin
        pdOut_q <= pwdata[15:0];
      end
      // completion wins over a clear in the same cycle
      done_q <= acked | (done_q & ~clrDone);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= answer;
      prdata_q <= (answer && !pwrite) ? rdSel : 32'h0000_0000;
      pslverr_q <= answer & (~mapped | busyErr);
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign pi.ctrlByte = ctrl_q;
  assign pi.outputDataWord = outWord_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : process_image_controller

// ===== process_image_register_access_assertions.sv
// assertions on the process-image link between controller and terminal
`timescale 1ns/1ps
`include "pimg_consts.svh"
module process_image_register_access_assertions
  import pimg_pkg::*;
#(
  parameter logic [15:0] FW_REVISION = `FW_REVISION_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic restartReq,
  input wire pimg_pkg::byte_t ctrlByte,
  input wire pimg_pkg::word_t outputDataWord,
  input wire pimg_pkg::byte_t statusByte,
  input wire pimg_pkg::word_t inputDataWord
);
  word_t codeQ;
  word_t featQ;
  wire isRead = ctrlByte[7] && !ctrlByte[6];
  wire isWrite = ctrlByte[7] && ctrlByte[6];
  wire [7:0] ackByte = isWrite ? (ctrlByte & 8'hBF) : ctrlByte;
  wire [5:0] regNum = ctrlByte[5:0];
  wire isReserved = isRead && !(regNum inside {6'h09, 6'h1F, 6'h20});

  // shadow of the code word and feature value as seen on the link
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      codeQ <= 16'h0000;
      featQ <= 16'h0000;
    end else if (restartReq) begin
      codeQ <= 16'h0000;
    end else if (ctrlByte == 8'hDF) begin
      codeQ <= outputDataWord;
    end else if (ctrlByte == 8'hE0 && codeQ == 16'h1235) begin
      featQ <= outputDataWord;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_waiting;
    ctrlByte[7] && statusByte != ackByte;
  endsequence
  sequence s_acked;
    ctrlByte[7] && statusByte == ackByte;
  endsequence

  property p_read_ack;
    isRead |=> statusByte == $past(ctrlByte);
  endproperty
  a_read_ack: assert property (p_read_ack)
    else $error("read ack is not a copy of the control byte");
  property p_write_ack;
    isWrite |=> statusByte == ($past(ctrlByte) & 8'hBF);
  endproperty
  a_write_ack: assert property (p_write_ack)
    else $error("write ack does not clear bit 6");
  property p_proc_mode;
    !ctrlByte[7] |=> !statusByte[7];
  endproperty
  a_proc_mode: assert property (p_proc_mode)
    else $error("register ack shown in process mode");
  property p_hold;
    s_waiting |=> $stable(ctrlByte);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before its ack");
  property p_release;
    s_acked |=> ctrlByte == {1'b0, $past(ctrlByte[6:0])};
  endproperty
  a_release: assert property (p_release)
    else $error("request not released after ack");
  property p_write_data;
    isWrite && statusByte != ackByte |=> $stable(outputDataWord);
  endproperty
  a_write_data: assert property (p_write_data)
    else $error("write value changed before its ack");
  property p_revision;
    ctrlByte == 8'h89 |=> inputDataWord == FW_REVISION;
  endproperty
  a_revision: assert property (p_revision)
    else $error("revision register read wrong");
  property p_code_read;
    ctrlByte == 8'h9F |=> inputDataWord == $past(codeQ);
  endproperty
  a_code_read: assert property (p_code_read)
    else $error("code word read wrong");
  property p_feat_read;
    ctrlByte == 8'hA0 |=> inputDataWord == $past(featQ);
  endproperty
  a_feat_read: assert property (p_feat_read)
    else $error("feature register read wrong");
  property p_reserved;
    isReserved |=> inputDataWord == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("unused register reads nonzero");
endmodule : process_image_register_access_assertions

// ===== process_image_register_access_tb.sv
// self-checking bench for the process-image register channel
`timescale 1ns/1ps
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin \
  errors++; $display("unexpected at %0t: got %h expected %h", \
  $time, got, exp); end end

module process_image_register_access_tb;
  import pimg_pkg::*;
  // arbitrary revision text
  localparam logic [15:0] REV = 16'h2B71;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  apb_data_t pwdata = 32'h0;
  apb_data_t prdata;
  logic pready;
  logic pslverr;
  logic restartReq = 1'b0;
  byte_t procStatus = 8'h00;
  word_t procInWord = 16'h0000;
  word_t procOutWord;
  word_t activeFeatures;
  logic writeUnlocked;
  logic regModeActive;
  int errors = 0;
  int nTests = 0;
  int seed = 32'h30FB;
  apb_data_t rdat;
  logic rerr;
  word_t codeM = 16'h0000;
  word_t featM = 16'h0000;
  word_t actM = 16'h0000;
  word_t lastRd = 16'h0000;
  word_t pdo;
  byte_t op;
  // bit 7 write, bit 6 unlock value, 5..0 register; FF restarts
  byte_t ops[18] = '{8'hA0, 8'h20, 8'hDF, 8'h1F, 8'hA0, 8'h20, 8'hFF,
    8'h1F, 8'hA0, 8'h20, 8'hDF, 8'h9F, 8'hA0, 8'h20, 8'h09, 8'h15,
    8'h95, 8'h15};
  regnum_t pick[4] = '{6'h09, 6'h1F, 6'h20, 6'h0A};

  always #10 clk = ~clk;

  pimg_if link ();
  process_image_terminal #(.FW_REVISION(REV)) i_process_image_terminal (
    .clk(clk), .reset_n(reset_n), .pi(link.terminal),
    .restartReq(restartReq), .procStatus(procStatus),
    .procInWord(procInWord), .procOutWord(procOutWord),
    .activeFeatures(activeFeatures), .writeUnlocked(writeUnlocked),
    .regModeActive(regModeActive));
  process_image_controller i_process_image_controller (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pi(link.controller));
  process_image_register_access_assertions #(.FW_REVISION(REV)) chk (
    .clk(clk), .reset_n(reset_n), .restartReq(restartReq),
    .ctrlByte(link.ctrlByte), .outputDataWord(link.outputDataWord),
    .statusByte(link.statusByte), .inputDataWord(link.inputDataWord));

  // ----------------------------------------------------------------------
  // expectations and bus tasks
  // ----------------------------------------------------------------------
  function automatic word_t expRead(regnum_t r);
    case (r)
      6'h09: return REV;
      6'h1F: return codeM;
      6'h20: return featM;
      default: return 16'h0000;
    endcase
  endfunction : expRead

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic fail();
    errors++;
    end_of_test();
  endtask : fail

  task automatic apb(input logic w, input logic [7:0] a, input apb_data_t d);
    int k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) fail();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // polls until the request is acked and idle, then clears done
  task automatic waitDone();
    int k = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      k++;
    end while (rdat[1:0] !== 2'b10 && k < 20);
    if (rdat[1:0] !== 2'b10) fail();
    apb(1'b1, 8'h04, 32'h2);
  endtask : waitDone

  task automatic step(input byte_t o);
    word_t v;
    v = o[6] ? 16'h1235 : 16'($random(seed));
    if (o == 8'hFF) begin
      @(posedge clk);
      restartReq <= 1'b1;
      @(posedge clk);
      restartReq <= 1'b0;
      codeM = 16'h0000;
      actM = featM;
      repeat (2) @(posedge clk);
      `CHK(writeUnlocked, 1'b0)
    end else begin
      apb(1'b1, 8'h00, {v, 9'h000, o[7], o[5:0]});
      repeat (2) @(posedge clk);
      `CHK(regModeActive, 1'b1)
      waitDone();
      if (o[7] && o[5:0] == 6'h1F) codeM = v;
      else if (o[7] && o[5:0] == 6'h20 && codeM == 16'h1235) featM = v;
      // a write must leave the last read data in place
      if (!o[7]) lastRd = expRead(o[5:0]);
      apb(1'b0, 8'h08, 32'h0);
      `CHK(rdat[15:0], lastRd)
      `CHK(writeUnlocked, codeM == 16'h1235)
    end
    `CHK(activeFeatures, actM)
  endtask : step

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ops[i]) step(ops[i]);
    $display("test directed register sequence done");
    repeat (40) begin
      op = 8'($random(seed));
      if (op[5]) op[5:0] = pick[op[4:3]];
      step(op);
    end
    $display("test random register traffic done");
    repeat (4) begin
      pdo = 16'($random(seed));
      @(posedge clk);
      procStatus <= 8'($random(seed));
      procInWord <= 16'($random(seed));
      apb(1'b1, 8'h0C, {16'h0000, pdo});
      apb(1'b0, 8'h10, 32'h0);
      `CHK(rdat[23:0], {1'b0, procStatus[6:0], procInWord})
      `CHK(procOutWord, pdo)
      `CHK(regModeActive, 1'b0)
    end
    $display("test process mode done");
    apb(1'b0, 8'h14, 32'h0);
    `CHK({rerr, rdat}, {1'b1, 32'h0})
    apb(1'b1, 8'h00, 32'h0000_0009);
    apb(1'b1, 8'h00, 32'h0000_001F);
    `CHK(rerr, 1'b1)
    waitDone();
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rdat[15:0], REV)
    $display("test refusals done");
    end_of_test();
  end
endmodule : process_image_register_access_tb
